/* File: tws_defs.svh */
// Offsets, field positions, reset values and timing counts of the timer/watchdog/sleep block
`ifndef TWS_DEFS_SVH
`define TWS_DEFS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define OFS_TICK_TIMER      12'h000
`define OFS_PRESCALE_CNT    12'h004
`define OFS_CORE_CONTROL    12'h008
`define OFS_WDOG_CONTROL    12'h00c
`define OFS_WAKE_CONTROL    12'h010
`define OFS_IRQ_MASK        12'h014
`define OFS_IRQ_FLAG        12'h018
`define OFS_MISC_CONTROL    12'h01c
`define OFS_PIN_CTRL_A      12'h020
`define OFS_PIN_CTRL_B      12'h024
`define OFS_PIN_CTRL_C      12'h028
`define OFS_STATUS          12'h02c
`define OFS_PC              12'h030
`define OFS_OPTION          12'h034

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define CC_SRC_BIT          5
`define CC_EDGE_BIT         4
`define CC_PSA_BIT          3
`define WD_ON_BIT           7
`define WD_PSWE_BIT         3
`define WK_CONV_BIT         3
`define WK_PORT_BIT         1
`define ST_TO_BIT           4
`define ST_PD_BIT           3
`define OPT_CLKDIV_BIT      0
`define OPT_WDSHORT_BIT     1
`define OPT_LXT_BIT         2
`define OPT_RC_BIT          3

// ----------------------------------------------------------------------------
// Reset values and vectors
// ----------------------------------------------------------------------------
`define RST_CORE_CONTROL    8'h3f
`define RST_PIN_CTRL        8'hff
`define WD_RESET_CLR_MASK   8'h4f
`define MISC_RESET_CLR_MASK 8'hcf
`define ST_POR_CLR_MASK     8'h1f
`define VEC_RESET           12'h000
`define VEC_PORT_CHANGE     12'h006
`define VEC_CONVERSION      12'h00c

// ----------------------------------------------------------------------------
// Times (us) and cycle counts at 25 MHz (40 ns)
// ----------------------------------------------------------------------------
`define CLK_NS              40
`define WDOG_LONG_US        18000
`define WDOG_SHORT_US       4500
`define RST_HOLD_US         18000
`define RST_HOLD_LXT_US     500000
`define WAKE_XTAL_US        2000
`define WAKE_RC_INSTR_CLOCK_DIV_OPT        32
`define WAKE_CONV_TAD       15
`define US_TO_CYC(us)       (((us) * 1000) / `CLK_NS)

`endif

/* File: tws_pkg.sv */
// Types of the timer/watchdog/sleep block
package tws_pkg;

  typedef enum logic [1:0] {
    ST_RUN   = 2'b00,
    ST_SLEEP = 2'b01,
    ST_WAKE  = 2'b10,
    ST_RESET = 2'b11
  } pwr_state_t;

  typedef struct packed {
    logic sleep;
    logic wdog_clear;
    logic irq_on;
    logic irq_off;
  } instr_t;

  typedef struct packed {
    logic        run;
    logic [11:0] pc;
    logic        pc_load;
  } core_ctl_t;

endpackage

/* File: timer_watchdog_sleep_wake.sv */
// Tick timer, prescaler, watchdog, reset hold, sleep and wake-up control
//
// Decided for this implementation: the APB slave port and the address map.
`timescale 1ns/1ns
`include "tws_defs.svh"

// Overview of operation
// - Prescaler count readable/writable; 3-bit select gives 1:2 to 1:256.
// - Prescaler cleared on timer write, ratio write, power-on, pin or watchdog reset.
// - Tick timer is 8 bits, +1 per instruction cycle unprescaled.
// - Instruction clock is oscillator/2 or oscillator/4 by option bit.
// - External source counts timer pin edges of the selected polarity.
// - Watchdog-clear and sleep instructions clear watchdog and its prescaler.
// - Tick timer stops in sleep unless converting with conversion wake set.
// - Watchdog runs in sleep and resets on time-out when enabled.
// - Unprescaled watchdog period is 18 ms or 4.5 ms by option.
// - Reset on power-on, low reset pin, or enabled watchdog time-out.
// - Reset held 18 ms, or 500 ms in low-frequency crystal mode.
// - Reset zeroes program counter, pins to input, clears watchdog.
// - Reset sets pin controls to ones, clears listed control, flag, mask bits.
// - Sleep stops oscillator and timers; enabled watchdog cleared, keeps running.
// - Sleep during conversion keeps oscillator running; tick timer too if conversion wake set.
// - Wake on reset pin, watchdog, enabled port change or conversion done.
// - Pin or watchdog wake resets; time-out and power-down flags tell which.
// - Port or conversion wake resumes: vector 0x06/0x0C if enabled, else next.
// - With watchdog on, wake-control bits cause no wake-up.
// - Wake latency: 32 clocks RC, 2 ms+32 crystal, 500 ms LOW_FREQ_CRYSTAL_MODE, 15 CONVERTER_CLOCK_PERIOD on a vectored conversion wake.
module timer_watchdog_sleep_wake #(
  parameter int WDOG_LONG_CYC  = `US_TO_CYC(`WDOG_LONG_US),
  parameter int WDOG_SHORT_CYC = `US_TO_CYC(`WDOG_SHORT_US),
  parameter int RST_HOLD_CYC   = `US_TO_CYC(`RST_HOLD_US),
  parameter int RST_LXT_CYC    = `US_TO_CYC(`RST_HOLD_LXT_US),
  parameter int WAKE_XTAL_CYC  = `US_TO_CYC(`WAKE_XTAL_US),
  parameter int TAD_CYC        = 4
) (
  // APB slave
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic                      pready,
  output logic [31:0]               prdata,
  output logic                      pslverr,
  // Instruction stream
  input  wire tws_pkg::instr_t      instr,
  // Pins and events
  input  wire logic                 ext_reset_n,
  input  wire logic                 tick_pin,
  input  wire logic                 port5_change,
  input  wire logic                 conv_busy,
  input  wire logic                 conv_done,
  input  wire logic                 wdog_osc_tick,
  // Core control
  output tws_pkg::core_ctl_t        core,
  output logic                      osc_run,
  output logic                      pins_input,
  output logic                      sys_reset,
  output logic                      global_irq_en
);
  import tws_pkg::*;

  localparam int WCW = 32;

  initial begin
    if (WDOG_SHORT_CYC < 1 || WDOG_LONG_CYC < WDOG_SHORT_CYC || RST_HOLD_CYC < 1 ||
        RST_LXT_CYC < 1 || WAKE_XTAL_CYC < 1 || TAD_CYC < 1)
      $error("timer_watchdog_sleep_wake: bad timing parameter");
  end

  // --------------------------------------------------------------------------
  // Functions
  // --------------------------------------------------------------------------
  function automatic logic [7:0] ratio_mask(input logic [2:0] sel);
    ratio_mask = 8'((9'h002 << sel) - 9'h001);
  endfunction

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  logic [7:0]  tick_timer_r, tick_prescale_count_r, core_control_reg_r;
  logic [7:0]  watchdog_control_reg_r, wake_control_reg_r, irq_mask_reg_r, irq_flag_reg_r;
  logic [7:0]  misc_control_reg_r, status_reg_r, option_r;
  logic [7:0]  pin_control_reg_a_r, pin_control_reg_b_r, pin_control_reg_c_r;
  logic [11:0] program_counter_reg_r;
  pwr_state_t  state_r;
  logic [WCW-1:0] wdog_cnt_r, hold_cnt_r;
  logic [7:0]  wdog_pre_r;
  logic        pin_d_r;
  logic [1:0]  div_cnt_r;
  logic        por_done_r, irq_en_r, wake_vec_r;
  logic [11:0] wake_pc_r;

  logic wr, rd, wr_timer, wr_ratio, timeout, wdog_on, conv_wake_keep;
  logic wake_port, wake_conv, ext_rst, wdog_step, instr_tick, src_tick, ptick;
  logic [WCW-1:0] wdog_limit, hold_limit, wake_limit;

  assign wr        = psel && penable && pwrite;
  assign rd        = psel && !pwrite;
  assign wr_timer  = wr && paddr == `OFS_TICK_TIMER;
  // Any write to the control register rewrites the ratio bits, so it clears the prescaler
  assign wr_ratio  = wr && paddr == `OFS_CORE_CONTROL;
  assign wdog_on   = watchdog_control_reg_r[`WD_ON_BIT];
  assign ext_rst   = !ext_reset_n;
  assign wake_port = !wdog_on && wake_control_reg_r[`WK_PORT_BIT] && port5_change;
  assign wake_conv = !wdog_on && wake_control_reg_r[`WK_CONV_BIT] && conv_done;
  assign conv_wake_keep = conv_busy && wake_control_reg_r[`WK_CONV_BIT];

  // --------------------------------------------------------------------------
  // Instruction clock, Fosc/2 or Fosc/4 from pclk
  // --------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_r <= 2'h0;
    end else begin
      div_cnt_r <= div_cnt_r + 2'h1;
    end
  end
  assign instr_tick = option_r[`OPT_CLKDIV_BIT] ? (div_cnt_r == 2'h3) : div_cnt_r[0];

  // --------------------------------------------------------------------------
  // Tick timer and prescaler
  // --------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_d_r <= 1'b0;
    end else begin
      pin_d_r <= tick_pin;
    end
  end
  // Edge select: 0 rising, 1 falling
  assign src_tick = core_control_reg_r[`CC_SRC_BIT] ?
                    (core_control_reg_r[`CC_EDGE_BIT] ? (pin_d_r && !tick_pin)
                                                      : (!pin_d_r && tick_pin))
                    : instr_tick;
  assign ptick = (state_r == ST_RUN || (state_r == ST_SLEEP && conv_wake_keep)) &&
                 src_tick;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_prescale_count_r <= 8'h00;
      tick_timer_r          <= 8'h00;
    end else if (sys_reset || wr_timer || wr_ratio) begin
      tick_prescale_count_r <= 8'h00;
      tick_timer_r          <= wr_timer ? pwdata[7:0] : tick_timer_r;
    end else if (wr && paddr == `OFS_PRESCALE_CNT) begin
      tick_prescale_count_r <= pwdata[7:0];
    end else if (ptick) begin
      if (core_control_reg_r[`CC_PSA_BIT]) begin
        tick_timer_r <= tick_timer_r + 8'h01;
      end else if ((tick_prescale_count_r & ratio_mask(core_control_reg_r[2:0])) ==
                   ratio_mask(core_control_reg_r[2:0])) begin
        tick_prescale_count_r <= 8'h00;
        tick_timer_r          <= tick_timer_r + 8'h01;
      end else begin
        tick_prescale_count_r <= tick_prescale_count_r + 8'h01;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Watchdog on its RC oscillator tick
  // --------------------------------------------------------------------------
  assign wdog_limit = option_r[`OPT_WDSHORT_BIT] ? WCW'(WDOG_SHORT_CYC)
                                                 : WCW'(WDOG_LONG_CYC);
  assign wdog_step  = wdog_osc_tick && (!watchdog_control_reg_r[`WD_PSWE_BIT] ||
                      (wdog_pre_r & ratio_mask(watchdog_control_reg_r[2:0])) ==
                      ratio_mask(watchdog_control_reg_r[2:0]));
  assign timeout    = wdog_on && state_r != ST_RESET && wdog_step &&
                      wdog_cnt_r >= wdog_limit - WCW'(1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdog_cnt_r <= '0;
      wdog_pre_r <= 8'h00;
    end else if (sys_reset || instr.wdog_clear || instr.sleep || !wdog_on) begin
      wdog_cnt_r <= '0;
      wdog_pre_r <= 8'h00;
    end else if (wdog_osc_tick) begin
      wdog_pre_r <= wdog_step ? 8'h00 : wdog_pre_r + 8'h01;
      if (wdog_step) wdog_cnt_r <= wdog_cnt_r + WCW'(1);
    end
  end

  // --------------------------------------------------------------------------
  // Power state machine
  // --------------------------------------------------------------------------
  assign hold_limit = option_r[`OPT_LXT_BIT] ? WCW'(RST_LXT_CYC) : WCW'(RST_HOLD_CYC);
  always_comb begin
    if (wake_vec_r && wake_pc_r == `VEC_CONVERSION)
      wake_limit = WCW'(`WAKE_CONV_TAD * TAD_CYC);
    else if (option_r[`OPT_LXT_BIT])
      wake_limit = WCW'(RST_LXT_CYC);
    else if (option_r[`OPT_RC_BIT])
      wake_limit = WCW'(`WAKE_RC_INSTR_CLOCK_DIV_OPT);
    else
      wake_limit = WCW'(WAKE_XTAL_CYC + `WAKE_RC_INSTR_CLOCK_DIV_OPT);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r    <= ST_RESET;
      hold_cnt_r <= '0;
      por_done_r <= 1'b0;
      wake_vec_r <= 1'b0;
      wake_pc_r  <= `VEC_RESET;
    end else begin
      case (state_r)
        ST_RUN: begin
          hold_cnt_r <= '0;
          if (ext_rst || timeout) begin
            state_r <= ST_RESET;
          end else if (instr.sleep) begin
            state_r <= ST_SLEEP;
          end
        end
        ST_SLEEP: begin
          hold_cnt_r <= '0;
          if (ext_rst || timeout) begin
            state_r <= ST_RESET;
          end else if (wake_port || wake_conv) begin
            state_r    <= ST_WAKE;
            wake_vec_r <= irq_en_r;
            wake_pc_r  <= wake_conv ? `VEC_CONVERSION : `VEC_PORT_CHANGE;
          end
        end
        ST_WAKE: begin
          hold_cnt_r <= hold_cnt_r + WCW'(1);
          if (ext_rst || timeout) begin
            state_r <= ST_RESET;
          end else if (hold_cnt_r >= wake_limit - WCW'(1)) begin
            state_r <= ST_RUN;
          end
        end
        ST_RESET: begin
          if (ext_rst) begin
            hold_cnt_r <= '0;
          end else if (hold_cnt_r >= hold_limit - WCW'(1)) begin
            state_r    <= ST_RUN;
            por_done_r <= 1'b1;
            hold_cnt_r <= '0;
          end else begin
            hold_cnt_r <= hold_cnt_r + WCW'(1);
          end
        end
        default: state_r <= ST_RESET;
      endcase
    end
  end

  assign sys_reset  = state_r == ST_RESET;
  assign osc_run    = state_r != ST_SLEEP || conv_busy;
  assign pins_input = sys_reset;
  assign global_irq_en = irq_en_r;
  assign core.run      = state_r == ST_RUN;
  assign core.pc       = program_counter_reg_r;
  assign core.pc_load  = state_r == ST_WAKE && hold_cnt_r >= wake_limit - WCW'(1) && wake_vec_r;

  // --------------------------------------------------------------------------
  // Program counter and global interrupt enable
  // --------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      program_counter_reg_r <= `VEC_RESET;
      irq_en_r              <= 1'b0;
    end else if (sys_reset) begin
      program_counter_reg_r <= `VEC_RESET;
      irq_en_r              <= 1'b0;
    end else begin
      if (core.pc_load) program_counter_reg_r <= wake_pc_r;
      else if (wr && paddr == `OFS_PC) program_counter_reg_r <= pwdata[11:0];
      if (instr.irq_on) irq_en_r <= 1'b1;
      else if (instr.irq_off) irq_en_r <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Control registers
  // --------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_control_reg_r     <= `RST_CORE_CONTROL;
      watchdog_control_reg_r <= 8'h00;
      wake_control_reg_r     <= 8'h00;
      irq_mask_reg_r         <= 8'h00;
      irq_flag_reg_r         <= 8'h00;
      misc_control_reg_r     <= 8'h00;
      pin_control_reg_a_r    <= `RST_PIN_CTRL;
      pin_control_reg_b_r    <= `RST_PIN_CTRL;
      pin_control_reg_c_r    <= `RST_PIN_CTRL;
      option_r               <= 8'h00;
    end else if (sys_reset) begin
      pin_control_reg_a_r    <= `RST_PIN_CTRL;
      pin_control_reg_b_r    <= `RST_PIN_CTRL;
      pin_control_reg_c_r    <= `RST_PIN_CTRL;
      watchdog_control_reg_r <= watchdog_control_reg_r & `WD_RESET_CLR_MASK;
      misc_control_reg_r     <= misc_control_reg_r & `MISC_RESET_CLR_MASK;
      irq_flag_reg_r         <= 8'h00;
      irq_mask_reg_r         <= 8'h00;
    end else if (wr) begin
      case (paddr)
        `OFS_CORE_CONTROL: core_control_reg_r     <= pwdata[7:0];
        `OFS_WDOG_CONTROL: watchdog_control_reg_r <= pwdata[7:0] & 8'hef;
        `OFS_WAKE_CONTROL: wake_control_reg_r     <= pwdata[7:0];
        `OFS_IRQ_MASK:     irq_mask_reg_r         <= pwdata[7:0];
        `OFS_IRQ_FLAG:     irq_flag_reg_r         <= pwdata[7:0];
        `OFS_MISC_CONTROL: misc_control_reg_r     <= pwdata[7:0];
        `OFS_PIN_CTRL_A:   pin_control_reg_a_r    <= pwdata[7:0];
        `OFS_PIN_CTRL_B:   pin_control_reg_b_r    <= pwdata[7:0];
        `OFS_PIN_CTRL_C:   pin_control_reg_c_r    <= pwdata[7:0];
        `OFS_OPTION:       option_r               <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // Status: time-out and power-down flags identify the reset source
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_reg_r <= 8'h18;
    end else if (!por_done_r) begin
      status_reg_r <= (status_reg_r & `ST_POR_CLR_MASK) | 8'h18;
    end else if (timeout) begin
      status_reg_r[`ST_TO_BIT] <= 1'b0;
      status_reg_r[`ST_PD_BIT] <= state_r != ST_SLEEP;
    end else if (ext_rst && state_r != ST_RESET) begin
      status_reg_r[`ST_TO_BIT] <= 1'b1;
      status_reg_r[`ST_PD_BIT] <= state_r != ST_SLEEP;
    end else if (instr.wdog_clear) begin
      status_reg_r[`ST_TO_BIT] <= 1'b1;
      status_reg_r[`ST_PD_BIT] <= 1'b1;
    end else if (instr.sleep && state_r == ST_RUN) begin
      status_reg_r[`ST_TO_BIT] <= 1'b1;
      status_reg_r[`ST_PD_BIT] <= 1'b0;
    end else if (wr && paddr == `OFS_STATUS) begin
      status_reg_r[7:5] <= pwdata[7:5];
      status_reg_r[2:0] <= pwdata[2:0];
    end
  end

  // --------------------------------------------------------------------------
  // APB read path, zero wait states
  // --------------------------------------------------------------------------
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd && !penable) begin
      case (paddr)
        `OFS_TICK_TIMER:   prdata <= {24'h000000, tick_timer_r};
        `OFS_PRESCALE_CNT: prdata <= {24'h000000, tick_prescale_count_r};
        `OFS_CORE_CONTROL: prdata <= {24'h000000, core_control_reg_r};
        `OFS_WDOG_CONTROL: prdata <= {24'h000000, watchdog_control_reg_r};
        `OFS_WAKE_CONTROL: prdata <= {24'h000000, wake_control_reg_r};
        `OFS_IRQ_MASK:     prdata <= {24'h000000, irq_mask_reg_r};
        `OFS_IRQ_FLAG:     prdata <= {24'h000000, irq_flag_reg_r};
        `OFS_MISC_CONTROL: prdata <= {24'h000000, misc_control_reg_r};
        `OFS_PIN_CTRL_A:   prdata <= {24'h000000, pin_control_reg_a_r};
        `OFS_PIN_CTRL_B:   prdata <= {24'h000000, pin_control_reg_b_r};
        `OFS_PIN_CTRL_C:   prdata <= {24'h000000, pin_control_reg_c_r};
        `OFS_STATUS:       prdata <= {24'h000000, status_reg_r};
        `OFS_PC:           prdata <= {20'h00000, program_counter_reg_r};
        `OFS_OPTION:       prdata <= {24'h000000, option_r};
        default:           prdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule

/* File: tws_assertions.sv */
// Port-level checks of the timer/watchdog/sleep block
`timescale 1ns/1ns
`include "tws_defs.svh"
module tws_assertions (
  // Watched ports
  input wire logic               pclk,
  input wire logic               presetn,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pready,
  input wire logic               pslverr,
  input wire tws_pkg::instr_t    instr,
  input wire logic               ext_reset_n,
  input wire tws_pkg::core_ctl_t core,
  input wire logic               osc_run,
  input wire logic               pins_input,
  input wire logic               sys_reset,
  input wire logic               global_irq_en
);
  import tws_pkg::*;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_sleep_taken;
    core.run && instr.sleep && ext_reset_n;
  endsequence
  sequence s_down;
    !core.run [*2];
  endsequence
  property p_apb;
    psel && penable |-> pready && !pslverr;
  endproperty
  property p_sleep;
    s_sleep_taken |=> s_down;
  endproperty
  property p_run_osc;
    core.run |-> osc_run;
  endproperty
  property p_rst_pins;
    sys_reset |-> pins_input && !core.run;
  endproperty
  property p_pin_rst;
    !ext_reset_n |-> ##[0:2] sys_reset;
  endproperty
  property p_hold;
    $rose(sys_reset) |=> sys_reset [*8];
  endproperty
  property p_irq_on;
    instr.irq_on && !instr.irq_off && !sys_reset |=> global_irq_en;
  endproperty
  property p_vec;
    core.pc_load |-> global_irq_en;
  endproperty
  property p_pc0;
    $fell(sys_reset) |-> core.pc == `VEC_RESET;
  endproperty
  a_apb: assert property (p_apb) else $error("APB answer wrong");
  a_sleep: assert property (p_sleep) else $error("sleep not entered");
  a_run_osc: assert property (p_run_osc) else $error("oscillator off in run");
  a_rst_pins: assert property (p_rst_pins) else $error("pins not input in reset");
  a_pin_rst: assert property (p_pin_rst) else $error("pin reset missed");
  a_hold: assert property (p_hold) else $error("reset hold too short");
  a_irq_on: assert property (p_irq_on) else $error("irq enable lost");
  a_vec: assert property (p_vec) else $error("vector load with irq off");
  a_pc0: assert property (p_pc0) else $error("pc not zero after reset");
endmodule
bind timer_watchdog_sleep_wake tws_assertions i_tws_assertions (.pclk, .presetn, .psel,
  .penable, .pready, .pslverr, .instr, .ext_reset_n, .core, .osc_run, .pins_input,
  .sys_reset, .global_irq_en);

/* File: timer_watchdog_sleep_wake_tb_top.sv */
// Self-checking bench of the timer/watchdog/sleep block
`timescale 1ns/1ns
`include "tws_defs.svh"
module timer_watchdog_sleep_wake_tb_top;
  import tws_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, osc_run, pins_input, sys_reset, global_irq_en;
  logic ext_reset_n = 1, tick_pin = 0, port5_change = 0, wdog_osc_tick = 0;
  logic conv_busy = 0, conv_done = 0;
  instr_t instr = '0;
  core_ctl_t core;
  int error_cnt = 0, samples_checked = 0, cyc = 0, n;
  always #20 pclk = ~pclk;
  timer_watchdog_sleep_wake #(.WDOG_LONG_CYC(200), .WDOG_SHORT_CYC(50), .RST_HOLD_CYC(20),
    .WAKE_XTAL_CYC(10)) i_timer_watchdog_sleep_wake (.pclk,
    .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .instr,
    .ext_reset_n, .tick_pin, .port5_change, .conv_busy, .conv_done, .wdog_osc_tick,
    .core, .osc_run, .pins_input, .sys_reset, .global_irq_en);
  task print_verdict();
    $display("Mismatches %0d, comparisons %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 30000) begin
      error_cnt++;
      print_verdict();
    end
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // APB transfer, one idle cycle after it
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task edges(input int k);
    repeat (k) begin
      tick_pin <= 1;
      repeat (4) @(posedge pclk);
      tick_pin <= 0;
      repeat (4) @(posedge pclk);
    end
  endtask
  task wd(input int k);
    repeat (k) begin
      wdog_osc_tick <= 1;
      @(posedge pclk);
      wdog_osc_tick <= 0;
      @(posedge pclk);
    end
  endtask
  task op(input instr_t v);
    instr <= v;
    @(posedge pclk);
    instr <= '0;
    @(posedge pclk);
  endtask
  task wait_run();
    n = 0;
    while (core.run !== 1'b1 && n < 3000) begin
      @(posedge pclk);
      n++;
    end
  endtask
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    wait_run();
    check(core.run, 1);
    apb(0, `OFS_PIN_CTRL_A, 0);
    check(rd, 32'h000000ff);
    apb(0, `OFS_IRQ_MASK, 0);
    check(rd, 32'h00000000);
    apb(0, 12'h0fc, 0);
    check(rd, 32'h00000000);
    apb(1, `OFS_CORE_CONTROL, 32'h00000027);
    apb(1, `OFS_PRESCALE_CNT, 32'h0000005a);
    apb(0, `OFS_PRESCALE_CNT, 0);
    check(rd, 32'h0000005a);
    apb(1, `OFS_TICK_TIMER, 32'h00000010);
    apb(0, `OFS_PRESCALE_CNT, 0);
    check(rd, 32'h00000000);
    edges(3);
    apb(0, `OFS_PRESCALE_CNT, 0);
    check(rd, 32'h00000003);
    apb(1, `OFS_CORE_CONTROL, 32'h00000020);
    apb(0, `OFS_PRESCALE_CNT, 0);
    check(rd, 32'h00000000);
    edges(6);
    apb(0, `OFS_TICK_TIMER, 0);
    check(rd, 32'h00000013);
    apb(1, `OFS_CORE_CONTROL, 32'h00000038);
    edges(5);
    apb(0, `OFS_TICK_TIMER, 0);
    check(rd, 32'h00000018);
    apb(1, `OFS_CORE_CONTROL, 32'h00000008);
    apb(1, `OFS_TICK_TIMER, 0);
    repeat (39) @(posedge pclk);
    apb(0, `OFS_TICK_TIMER, 0);
    check(rd, 32'h00000014);
    apb(1, `OFS_OPTION, 32'h00000001);
    apb(1, `OFS_TICK_TIMER, 0);
    repeat (39) @(posedge pclk);
    apb(0, `OFS_TICK_TIMER, 0);
    check(rd, 32'h0000000a);
    apb(1, `OFS_WDOG_CONTROL, 0);
    apb(1, `OFS_WAKE_CONTROL, 32'h00000002);
    op(instr_t'(4'b0010));
    op(instr_t'(4'b1000));
    check(core.run, 0);
    check(osc_run, 0);
    port5_change <= 1;
    @(posedge pclk);
    port5_change <= 0;
    wait_run();
    check(core.run, 1);
    apb(0, `OFS_PC, 0);
    check(rd, 32'(`VEC_PORT_CHANGE));
    apb(1, `OFS_WAKE_CONTROL, 32'h00000008);
    conv_busy <= 1;
    op(instr_t'(4'b1000));
    check(osc_run, 1);
    conv_busy <= 0;
    conv_done <= 1;
    @(posedge pclk);
    conv_done <= 0;
    wait_run();
    check(core.run, 1);
    apb(0, `OFS_PC, 0);
    check(rd, 32'(`VEC_CONVERSION));
    apb(1, `OFS_WAKE_CONTROL, 0);
    apb(1, `OFS_PIN_CTRL_A, 0);
    apb(1, `OFS_WDOG_CONTROL, 32'h00000080);
    apb(1, `OFS_PRESCALE_CNT, 32'h00000033);
    wd(150);
    op(instr_t'(4'b0100));
    wd(150);
    check(sys_reset, 0);
    n = 0;
    while (sys_reset !== 1'b1 && n < 100) begin
      wd(1);
      n++;
    end
    check(sys_reset, 1);
    check(n, 50);
    wait_run();
    apb(0, `OFS_PIN_CTRL_A, 0);
    check(rd, 32'h000000ff);
    apb(0, `OFS_PRESCALE_CNT, 0);
    check(rd, 32'h00000000);
    apb(0, `OFS_STATUS, 0);
    check(rd, 32'h1 << `ST_PD_BIT);
    ext_reset_n <= 0;
    repeat (3) @(posedge pclk);
    check(sys_reset, 1);
    ext_reset_n <= 1;
    wait_run();
    check(core.run, 1);
    apb(0, `OFS_STATUS, 0);
    check(rd, (32'h1 << `ST_TO_BIT) | (32'h1 << `ST_PD_BIT));
    print_verdict();
  end
endmodule
